// >>> lrr_cfg.svh
// Constants for the loader run and reset command interpreter
`ifndef LRR_CFG_SVH
`define LRR_CFG_SVH
`define LRR_CMD_RUN 8'h22
`define LRR_CMD_RESET 8'h25
`define LRR_LEN_RUN 8'h07
`define LRR_LEN_RESET 8'h03
`define LRR_ACK 8'hcc
`define LRR_NAK 8'h33
`define LRR_MAX_LEN 8'h0b
`define LRR_FIFO_DEPTH 32
`define LRR_FIFO_AW 5
`endif

// >>> lrr_host.sv
// Host model for the run and reset command interpreter
`timescale 1ns/1ps
module lrr_host (
  input wire logic clk,
  input wire logic rst_n,
  output lrr_pkg::lrr_byte_t rx,
  input wire logic rx_ready,
  input wire lrr_pkg::lrr_byte_t tx,
  output logic tx_ready,
  input wire logic slow
);
  import lrr_pkg::*;
  logic [7:0] q[$];
  logic [7:0] resp[$];
  logic [3:0] cnt;
  initial begin
    rx = '0;
    tx_ready = 1'b0;
    cnt = 4'h0;
  end
  // Idle data flips so a stale byte never looks fresh
  always @(posedge clk) begin
    if (rx.valid && rx_ready) void'(q.pop_front());
    if (q.size() > 0) rx <= '{1'b1, q[0]};
    else rx <= '{1'b0, ~rx.data};
    cnt <= cnt + 4'h1;
    tx_ready <= rst_n && (!slow || cnt == 4'hf);
    // Every non-zero byte taken counts as an answer
    if (tx.valid && tx_ready && tx.data != 8'h00) resp.push_back(tx.data);
  end
endmodule // lrr_host

// >>> lrr_pkg.sv
// Types for the loader run and reset command interpreter
package lrr_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lrr_byte_t;
  typedef enum logic [2:0] {
    ST_LEN, ST_SUM, ST_DATA, ST_DRAIN, ST_RESP, ST_WAIT, ST_ACT
  } lrr_state_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } lrr_jump_t;
endpackage

// >>> lrr_top.sv
// Run and reset command interpreter of the serial loader, with input FIFO
// How it works
// R1 - Command byte 0x22 asks to run from the 32-bit address that follows.
// R2 - A run packet is 7 bytes: length, checksum, command, address MSB first.
// R3 - For a run the ack byte is sent before the jump is issued.
// R4 - A reset packet is 3 bytes: length, checksum equal to command, 0x25.
// R5 - A reset request raises a full device reset, not a jump.
// R6 - For a reset the ack byte is sent before the reset is issued.
// R7 - The host may send reset after an error to start talking afresh.
// R8 - A good packet is answered 0xcc and a bad one 0x33.
// R9 - Byte one is the whole length; the checksum covers data bytes only.
// R10 - The sum is modulo 256; bad sum or length gives no run or reset.
`timescale 1ns/1ps
`include "lrr_cfg.svh"

module lrr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic rdy;
  } lrr_fifo_st_t;
  lrr_fifo_st_t st_q, st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop, empty;

  // Extra pointer bit tells full from empty when the indices meet
  function automatic logic is_full(input logic [AW:0] w,
                                   input logic [AW:0] r);
    is_full = (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
  endfunction

  assign push = in_valid && st_q.rdy;
  assign empty = st_q.wp == st_q.rp;
  assign pop = out_ready && !empty;
  assign in_ready = st_q.rdy;
  assign out_valid = !empty;
  assign out_data = mem[st_q.rp[AW-1:0]];

  // Ready is worked out ahead from the next pointers, so it leaves a flop
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    st_d.rdy = !is_full(st_d.wp, st_d.rp);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_q.wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{wp: '0, rp: '0, rdy: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n) // R2
    !in_ready |=> st_q.wp == $past(st_q.wp))
    else $error("fifo written while full");
  a_fifo_ready_flop: assert property (@(posedge clk) disable iff (!rst_n) // R2
    in_ready == !is_full(st_q.wp, st_q.rp))
    else $error("fifo ready out of step");
endmodule // lrr_fifo

module lrr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire lrr_pkg::lrr_byte_t rx,
  output logic rx_ready,
  output lrr_pkg::lrr_byte_t tx,
  input wire logic tx_ready,
  output lrr_pkg::lrr_jump_t jump,
  output logic sys_reset_req
);
  import lrr_pkg::*;

  // ------------------------------------------------------------
  // Input buffering
  // ------------------------------------------------------------
  logic f_valid, f_ready;
  logic [7:0] f_data;
  lrr_fifo #(.WIDTH(8), .DEPTH(`LRR_FIFO_DEPTH), .AW(`LRR_FIFO_AW))
    lrr_fifo_inst (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx.valid),
    .in_ready(rx_ready),
    .in_data(rx.data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    lrr_state_t st;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [7:0] sum;
    logic [7:0] csum;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic good;
    lrr_byte_t tx;
    lrr_jump_t jump;
    logic rst;
  } lrr_state_s_t;
  lrr_state_s_t s_q, s_d;

  function automatic logic len_ok(input logic [7:0] cmd,
                                  input logic [7:0] len);
    len_ok = (cmd == `LRR_CMD_RUN && len == `LRR_LEN_RUN) || // R2
             (cmd == `LRR_CMD_RESET && len == `LRR_LEN_RESET); // R4
  endfunction

  logic take;
  assign take = f_valid && f_ready;
  // Nothing is taken while an answer is out; the FIFO soaks up the stream
  assign f_ready = s_q.st == ST_LEN || s_q.st == ST_SUM ||
                   s_q.st == ST_DATA || s_q.st == ST_DRAIN;

  always_comb begin
    s_d = s_q;
    s_d.jump.valid = 1'b0;
    case (s_q.st)
      ST_LEN: begin
        // Zero bytes are idle padding on the link
        if (take && f_data != 8'h00) begin
          s_d.len = f_data; // R9
          s_d.cnt = 8'h02;
          s_d.sum = 8'h00;
          s_d.st = ST_SUM;
        end
      end
      ST_SUM: begin
        if (take) begin
          s_d.csum = f_data;
          s_d.cnt = 8'h03;
          // Lengths beyond LRR_MAX_LEN (0x0b) are not parsed; drain them
          if (s_q.len < 8'h03 || s_q.len > `LRR_MAX_LEN) begin
            s_d.good = 1'b0;
            s_d.st = (s_q.len < 8'h03) ? ST_RESP : ST_DRAIN;
          end else begin
            s_d.st = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (take) begin
          s_d.sum = s_q.sum + f_data; // R9 R10
          if (s_q.cnt == 8'h03) begin
            s_d.cmd = f_data;
          end else begin
            s_d.addr = {s_q.addr[23:0], f_data}; // R2
          end
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == s_q.len) begin
            s_d.good = (s_q.sum + f_data) == s_q.csum; // R10
            s_d.st = ST_RESP;
          end
        end
      end
      ST_DRAIN: begin
        if (take) begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == s_q.len) begin
            s_d.st = ST_RESP;
          end
        end
      end
      ST_RESP: begin
        // A good sum earns an ack even for a command that is not ours
        s_d.tx.valid = 1'b1;
        s_d.tx.data = s_q.good ? `LRR_ACK : `LRR_NAK; // R8
        s_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        // Action only after the answer byte has left
        if (tx_ready) begin
          s_d.tx.valid = 1'b0;
          s_d.st = s_q.good ? ST_ACT : ST_LEN; // R3 R6 R10
        end
      end
      ST_ACT: begin
        // Address is held steady beside a one-cycle jump pulse
        s_d.st = ST_LEN;
        if (len_ok(s_q.cmd, s_q.len)) begin
          if (s_q.cmd == `LRR_CMD_RUN) begin
            s_d.jump.valid = 1'b1; // R1 R3
            s_d.jump.addr = s_q.addr;
          end else begin
            s_d.rst = 1'b1; // R5 R6 R7
          end
        end
      end
      default: begin
        s_d.st = ST_LEN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx = s_q.tx;
  assign jump = s_q.jump;
  assign sys_reset_req = s_q.rst;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Ack must have been on tx two edges before any jump or reset shows
  a_run_after_ack: assert property (@(posedge clk) disable iff (!rst_n) // R3
    $rose(jump.valid) |-> $past(tx.valid && tx.data == `LRR_ACK, 2))
    else $error("jump without prior ack");
  a_reset_after_ack: assert property (@(posedge clk) disable iff (!rst_n) // R6
    $rose(sys_reset_req) |-> $past(tx.valid && tx.data == `LRR_ACK, 2))
    else $error("reset without prior ack");
  a_run_cmd_code: assert property (@(posedge clk) disable iff (!rst_n) // R1
    jump.valid |-> s_q.cmd == 8'h22 && s_q.len == 8'h07)
    else $error("jump from wrong command");
  a_run_addr_order: assert property (@(posedge clk) disable iff (!rst_n) // R2
    jump.valid |-> jump.addr == s_q.addr)
    else $error("jump address differs from packet");
  a_addr_shift: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (s_q.st == ST_DATA && take && s_q.cnt > 8'h03) |=>
      s_q.addr == {$past(s_q.addr[23:0]), $past(f_data)})
    else $error("address not shifted in msb first");
  a_reset_cmd_code: assert property (@(posedge clk) disable iff (!rst_n) // R4
    $rose(sys_reset_req) |-> s_q.cmd == 8'h25 && s_q.len == 8'h03)
    else $error("reset from wrong command");
  a_reset_no_jump: assert property (@(posedge clk) disable iff (!rst_n) // R5
    $rose(sys_reset_req) |-> !jump.valid)
    else $error("reset and jump together");
  a_reset_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R5
    sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped early");
  a_resp_code: assert property (@(posedge clk) disable iff (!rst_n) // R8
    tx.valid |-> tx.data == 8'hcc || tx.data == 8'h33)
    else $error("bad response byte");
  a_tx_hold: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (tx.valid && !tx_ready) |=> tx.valid && $stable(tx.data))
    else $error("answer byte dropped before taken");
  a_jump_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R1
    jump.valid |=> !jump.valid)
    else $error("jump pulse too long");
  a_act_after_ack: assert property (@(posedge clk) disable iff (!rst_n) // R3
    s_q.st == ST_ACT |-> $past(tx.valid && tx_ready && tx.data == `LRR_ACK))
    else $error("action before ack left");
  a_nak_no_act: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (tx.valid && tx.data == 8'h33 && tx_ready) |=> ##1
      !jump.valid && !$rose(sys_reset_req))
    else $error("action after nak");
  a_drain_nak: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (s_q.st == ST_DRAIN && take && s_q.cnt == s_q.len) |=>
      s_q.st == ST_RESP && !s_q.good)
    else $error("long packet not refused");
  a_len_check: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (s_q.st == ST_ACT && s_q.len != `LRR_LEN_RUN) |=> !jump.valid)
    else $error("jump from packet of wrong length");
  a_sum_check: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (s_q.st == ST_RESP && s_q.good) |-> s_q.sum == s_q.csum)
    else $error("ack with bad checksum");
  a_short_len_nak: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (s_q.st == ST_SUM && take && s_q.len < 8'h03) |=>
      s_q.st == ST_RESP && !s_q.good)
    else $error("short packet not refused");
  a_zero_skip: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (s_q.st == ST_LEN && take && f_data == 8'h00) |=> s_q.st == ST_LEN)
    else $error("zero padding taken as length");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  c_run: cover property (@(posedge clk) jump.valid);
  c_reset: cover property (@(posedge clk) $rose(sys_reset_req));
  c_nak: cover property (@(posedge clk) tx.valid && tx.data == 8'h33);
  c_full: cover property (@(posedge clk) !rx_ready);
  c_drain: cover property (@(posedge clk) s_q.st == ST_DRAIN);
endmodule // lrr_top

// >>> lrr_top_test.sv
// Self-checking bench for the run and reset command interpreter
`timescale 1ns/1ps
module lrr_top_test;
  import lrr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic early = 1'b0;
  logic ready_low = 1'b0;
  lrr_byte_t rx;
  lrr_byte_t tx;
  logic rx_ready;
  logic tx_ready;
  logic sys_reset_req;
  lrr_jump_t jump;
  logic [31:0] jq[$];
  int fail_count = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  lrr_top lrr_top_inst (.clk(clk), .rst_n(rst_n), .rx(rx),
    .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .jump(jump),
    .sys_reset_req(sys_reset_req));
  lrr_host lrr_host_inst (.clk(clk), .rst_n(rst_n), .rx(rx),
    .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .slow(slow));
  always @(posedge clk) begin
    if (!rx_ready) ready_low <= 1'b1;
    if (jump.valid) jq.push_back(jump.addr);
    if ((jump.valid || sys_reset_req) && lrr_host_inst.resp.size() == 0)
      early <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b[$]);
    foreach (b[i]) lrr_host_inst.q.push_back(b[i]);
  endtask
  task automatic put_run(input logic [31:0] a, input logic [7:0] err);
    logic [7:0] s;
    s = 8'h22 + a[31:24] + a[23:16] + a[15:8] + a[7:0] + err;
    put({8'h07, s, 8'h22, a[31:24], a[23:16], a[15:8], a[7:0]});
  endtask
  task automatic settle(input int n);
    int k;
    k = 0;
    while (lrr_host_inst.resp.size() < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
    chk(lrr_host_inst.resp.size(), n);
  endtask
  task automatic fresh();
    lrr_host_inst.resp.delete();
    jq.delete();
    early = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_run();
    fresh();
    put_run(32'h8a5b_3c01, 8'h00);
    settle(1);
    chk(lrr_host_inst.resp[0], 8'hcc);
    chk(jq.size(), 1);
    chk(jq[0], 32'h8a5b_3c01);
    chk(early, 1'b0);
    $display("test run done");
  endtask
  task automatic t_bad();
    fresh();
    put({8'h00, 8'h00});
    put_run(32'h0000_1000, 8'h01);
    put({8'h03, 8'h20, 8'h20});
    put({8'h03, 8'h24, 8'h25});
    put({8'h04, 8'h26, 8'h25, 8'h01});
    settle(4);
    chk(lrr_host_inst.resp[0], 8'h33);
    chk(lrr_host_inst.resp[1], 8'hcc);
    chk(lrr_host_inst.resp[2], 8'h33);
    chk(lrr_host_inst.resp[3], 8'hcc);
    chk(jq.size() + sys_reset_req, 0);
    $display("test bad sum done");
  endtask
  task automatic t_len();
    fresh();
    put({8'h02, 8'h00});
    put({8'h0c});
    repeat (11) put({8'h00});
    put({8'h03, 8'h22, 8'h22});
    settle(3);
    chk(lrr_host_inst.resp[0], 8'h33);
    chk(lrr_host_inst.resp[1], 8'h33);
    chk(lrr_host_inst.resp[2], 8'hcc);
    chk(jq.size() + sys_reset_req, 0);
    $display("test length done");
  endtask
  task automatic t_fill();
    fresh();
    ready_low = 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 10; i++) put_run(32'hf000_0000 + i, 8'h00);
    settle(10);
    slow <= 1'b0;
    chk(ready_low, 1'b1);
    for (int i = 0; i < 10; i++) begin
      chk(lrr_host_inst.resp[i], 8'hcc);
      chk(jq[i], 32'hf000_0000 + i);
    end
    $display("test fill done");
  endtask
  task automatic t_reset();
    fresh();
    put({8'h03, 8'h25, 8'h25});
    settle(1);
    chk(lrr_host_inst.resp[0], 8'hcc);
    chk(sys_reset_req, 1'b1);
    chk(jq.size(), 0);
    chk(early, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(sys_reset_req, 1'b0);
    $display("test reset done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_run();
    t_bad();
    t_reset();
    t_run();
    t_len();
    t_fill();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule // lrr_top_test
